// ---- hw/iprm_pkg.sv ----
// Constants, register map and level helpers of the interrupt arbiter.
// Assumes a single 16-bit peripheral bus and one system clock.
package iprm_pkg;

  // Word-addressed module base in the 24-bit system map
  localparam logic [23:0] IPRM_BASE_ADDR = 24'h00f0e0;
  // Offset bits decoded inside the module window
  localparam int IPRM_OFF_BITS = 5;

  // Register offsets
  localparam logic [4:0] OFF_PRIO0 = 5'h00;
  localparam logic [4:0] OFF_PRIO1 = 5'h01;
  localparam logic [4:0] OFF_PRIO2 = 5'h02;
  localparam logic [4:0] OFF_PRIO3 = 5'h03;
  localparam logic [4:0] OFF_PRIO4 = 5'h04;
  localparam logic [4:0] OFF_PRIO5 = 5'h05;
  localparam logic [4:0] OFF_PRIO6 = 5'h06;
  localparam logic [4:0] OFF_VBASE = 5'h07;
  localparam logic [4:0] OFF_FM0 = 5'h08;
  localparam logic [4:0] OFF_FVL0 = 5'h09;
  localparam logic [4:0] OFF_FVH0 = 5'h0a;
  localparam logic [4:0] OFF_FM1 = 5'h0b;
  localparam logic [4:0] OFF_FVL1 = 5'h0c;
  localparam logic [4:0] OFF_FVH1 = 5'h0d;
  localparam logic [4:0] OFF_PEND0 = 5'h0e;
  localparam logic [4:0] OFF_PEND1 = 5'h0f;
  localparam logic [4:0] OFF_PEND2 = 5'h10;
  localparam logic [4:0] OFF_PEND3 = 5'h11;
  localparam logic [4:0] OFF_CTRL = 5'h16;

  // Writable-bit masks; cleared bits read as zero
  localparam logic [15:0] PRIO0_MASK = 16'hf3ff;
  localparam logic [15:0] PRIO2_MASK = 16'hc3ff;
  localparam logic [15:0] PRIO_MASK = 16'hffff;
  localparam logic [15:0] VBASE_MASK = 16'h3fff;
  localparam logic [15:0] FM_MASK = 16'h007f;
  localparam logic [15:0] FVH_MASK = 16'h001f;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // Control register layout
  localparam int CTRL_INT_BIT = 15;
  localparam int CTRL_LVL_LSB = 13;
  localparam int CTRL_VEC_LSB = 6;
  localparam int CTRL_DIS_BIT = 5;
  localparam logic [15:0] CTRL_ONES = 16'h001c;

  // Sources, fields and vector widths
  localparam int NUM_SRC = 64;
  localparam int NUM_FIELD_SRC = 56;
  localparam int VEC_W = 7;
  localparam int VBASE_W = 14;
  localparam int FVH_W = 5;
  localparam int ADDR_W = VBASE_W + VEC_W;
  // Registers whose codes 01..11 mean levels 1..3 (others 0..2)
  localparam logic [6:0] FROM1_REGS = 7'h01;
  // Code used by sources beyond the programmable fields
  localparam logic [1:0] FIXED_CODE = 2'h3;
  // Level that qualifies a fast interrupt
  localparam logic [1:0] FAST_LEVEL = 2'h2;

  // Presented-level codes
  localparam logic [1:0] PRES_NONE = 2'h0;
  localparam logic [1:0] PRES_L0 = 2'h1;
  localparam logic [1:0] PRES_L1 = 2'h2;
  localparam logic [1:0] PRES_L23 = 2'h3;

  typedef logic [15:0] iprm_word_type;

  // Field code to level; codes start at level 1 or level 0
  function automatic logic [1:0] iprm_level(input logic [1:0] code,
                                            input logic from1);
    iprm_level = from1 ? code : code - 2'h1;
  endfunction : iprm_level

  // Level to the code presented to the core
  function automatic logic [1:0] iprm_present(input logic [1:0] lvl);
    iprm_present = (lvl == 2'h0) ? PRES_L0 :
                   (lvl == 2'h1) ? PRES_L1 : PRES_L23;
  endfunction : iprm_present

endpackage : iprm_pkg

// ---- hw/iprm_lowest_enc.sv ----
// Lowest-numbered active request finder for one priority level.
// Assumes a combinational use inside the arbiter.
`timescale 1ns/100ps
module iprm_lowest_enc
  import iprm_pkg::*;
(
  input wire logic [NUM_SRC-1:0] req,
  output logic found,
  output logic [5:0] index
);

  // Scan downward so the last hit kept is the lowest number
  always_comb
  begin
    found = |req;
    index = 6'h00;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        index = 6'(i);
      end
    end
  end

endmodule : iprm_lowest_enc

// ---- hw/iprm_core.sv ----
// Interrupt arbiter: priority, vector and pending registers on the
// peripheral bus, winner selection and vector address to the core.
// Assumes request lines and bus strobes synchronous to sys_clk.
//
// Summary of operation
// - Registers decoded at base plus word offset
// - Seven priority registers at offsets zero-six
// - First priority register fields; bits 11-10 zero
// - Vector base at offset seven, top bits zero
// - Two fast match registers, vector low field
// - Fast address low/high registers per fast set
// - Pending status of 64 sources, four registers
// - Code 00 disables, others give levels
// - Normal address is base joined with vector
// - Level-two match uses fast address registers
// - Control level field encodes presented priority
`timescale 1ns/100ps
module iprm_core
  import iprm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [23:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  output logic bus_ack,
  input wire logic [NUM_SRC-1:0] irq_src,
  output logic irq_valid,
  output logic [1:0] presented_level,
  output logic [VEC_W-1:0] vector_num,
  output logic [ADDR_W-1:0] vector_addr,
  output logic fast_hit
);

  // Programmable state
  iprm_word_type prio_r [7]; // Priority registers
  iprm_word_type vbase_r; // Vector base
  iprm_word_type fm0_r; // Fast match 0
  iprm_word_type fvl0_r; // Fast address low 0
  iprm_word_type fvh0_r; // Fast address high 0
  iprm_word_type fm1_r; // Fast match 1
  iprm_word_type fvl1_r; // Fast address low 1
  iprm_word_type fvh1_r; // Fast address high 1
  logic global_irq_off_r; // Stops presentation to the core

  // Bus decode
  logic hit; // Address inside the module window
  logic [4:0] off; // Word offset
  logic wr_en; // Accepted write
  logic rd_en; // Accepted read
  iprm_word_type rd_nxt; // Read mux
  iprm_word_type wmask; // Writable bits of the addressed register

  // Arbitration
  logic [1:0] src_lvl [NUM_SRC]; // Level of each source
  logic [NUM_SRC-1:0] src_on; // Source enabled
  logic [NUM_SRC-1:0] pending; // Enabled and requesting
  logic [NUM_SRC-1:0] lvl_req [4]; // Requests split by level
  logic [3:0] lvl_found; // Level has a request
  logic [5:0] lvl_idx [4]; // Lowest source per level
  logic win_valid; // Any winner
  logic [1:0] win_lvl; // Winning level
  logic [5:0] win_src; // Winning source
  logic [VEC_W-1:0] win_vec; // Winning vector number
  logic fast0; // Match on set 0
  logic fast1; // Match on set 1
  logic [ADDR_W-1:0] addr_nxt; // Vector address to present

  assign hit = bus_addr[23:IPRM_OFF_BITS] ==
               IPRM_BASE_ADDR[23:IPRM_OFF_BITS];
  assign off = bus_addr[IPRM_OFF_BITS-1:0];
  assign wr_en = bus_wr && hit;
  assign rd_en = bus_rd && hit;

  // Writable bit mask per offset; reserved bits never store
  always_comb
  begin
    unique case (off)
      OFF_PRIO0: wmask = PRIO0_MASK;
      OFF_PRIO2: wmask = PRIO2_MASK;
      OFF_PRIO1, OFF_PRIO3, OFF_PRIO4, OFF_PRIO5, OFF_PRIO6:
        wmask = PRIO_MASK;
      // Top two bits of the base dropped
      OFF_VBASE: wmask = VBASE_MASK;
      // Match keeps only the vector field
      OFF_FM0, OFF_FM1: wmask = FM_MASK;
      OFF_FVL0, OFF_FVL1: wmask = PRIO_MASK;
      // High address keeps the low bits only
      OFF_FVH0, OFF_FVH1: wmask = FVH_MASK;
      default: wmask = REG_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int k = 0; k < 7; k++)
      begin
        prio_r[k] <= REG_RESET;
      end
    end
    else if (wr_en && off <= OFF_PRIO6)
    begin
      prio_r[off[2:0]] <= bus_wdata & wmask;
    end
  end

  // Vector base and fast sets
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vbase_r <= REG_RESET;
      fm0_r <= REG_RESET;
      fvl0_r <= REG_RESET;
      fvh0_r <= REG_RESET;
      fm1_r <= REG_RESET;
      fvl1_r <= REG_RESET;
      fvh1_r <= REG_RESET;
    end
    else if (wr_en)
    begin
      // Masked data, low address words stored whole; writes elsewhere fall through
      unique case (off)
        OFF_VBASE: vbase_r <= bus_wdata & wmask;
        OFF_FM0: fm0_r <= bus_wdata & wmask;
        OFF_FVL0: fvl0_r <= bus_wdata;
        OFF_FVH0: fvh0_r <= bus_wdata & wmask;
        OFF_FM1: fm1_r <= bus_wdata & wmask;
        OFF_FVL1: fvl1_r <= bus_wdata;
        OFF_FVH1: fvh1_r <= bus_wdata & wmask;
        default: ;
      endcase
    end
  end

  // Global disable bit of the control register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      global_irq_off_r <= 1'b0;
    end
    else if (wr_en && off == OFF_CTRL)
    begin
      global_irq_off_r <= bus_wdata[CTRL_DIS_BIT];
    end
  end

  // Per-source field decode; upper sources carry a fixed code
  for (genvar g = 0; g < NUM_SRC; g++)
  begin : g_src
    logic [1:0] code;
    if (g < NUM_FIELD_SRC)
    begin : g_field
      assign code = prio_r[g / 8][15 - 2 * (g % 8) -: 2];
    end
    else
    begin : g_fixed
      assign code = FIXED_CODE;
    end
    // Zero code disables, others map to levels
    assign src_on[g] = code != 2'h0;
    assign src_lvl[g] = iprm_level(code, FROM1_REGS[(g / 8) % 7]);
  end

  assign pending = irq_src & src_on;

  // Split pending requests by level
  always_comb
  begin
    for (int l = 0; l < 4; l++)
    begin
      lvl_req[l] = '0;
      for (int s = 0; s < NUM_SRC; s++)
      begin
        lvl_req[l][s] = pending[s] && src_lvl[s] == 2'(l);
      end
    end
  end

  // One lowest-number finder per level
  for (genvar l = 0; l < 4; l++)
  begin : g_lvl
    iprm_lowest_enc u_enc (
      .req(lvl_req[l]),
      .found(lvl_found[l]),
      .index(lvl_idx[l])
    );
  end

  // Highest level first, lowest number within it
  always_comb
  begin
    win_valid = 1'b1;
    if (lvl_found[3])
    begin
      win_lvl = 2'h3;
      win_src = lvl_idx[3];
    end
    else if (lvl_found[2])
    begin
      win_lvl = 2'h2;
      win_src = lvl_idx[2];
    end
    else if (lvl_found[1])
    begin
      win_lvl = 2'h1;
      win_src = lvl_idx[1];
    end
    else
    begin
      // Level zero or nothing at all
      win_valid = lvl_found[0];
      win_lvl = 2'h0;
      win_src = lvl_idx[0];
    end
  end

  assign win_vec = {1'b0, win_src};

  // Fast sets checked only for level two; set 0 first
  assign fast0 = win_lvl == FAST_LEVEL && win_vec == fm0_r[VEC_W-1:0];
  assign fast1 = win_lvl == FAST_LEVEL && win_vec == fm1_r[VEC_W-1:0];

  // Base-relative address unless a fast set matches
  always_comb
  begin
    if (fast0)
    begin
      addr_nxt = {fvh0_r[FVH_W-1:0], fvl0_r};
    end
    else if (fast1)
    begin
      addr_nxt = {fvh1_r[FVH_W-1:0], fvl1_r};
    end
    else
    begin
      addr_nxt = {vbase_r[VBASE_W-1:0], win_vec};
    end
  end

  // Presentation to the core, one cycle behind the requests
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_valid <= 1'b0;
      presented_level <= PRES_NONE;
      vector_num <= '0;
      vector_addr <= '0;
      fast_hit <= 1'b0;
    end
    else
    begin
      // The global disable clears valid and level; vector, address and fast_hit still follow the winner
      irq_valid <= win_valid && !global_irq_off_r;
      presented_level <= (win_valid && !global_irq_off_r) ?
                         iprm_present(win_lvl) : PRES_NONE;
      vector_num <= win_vec;
      vector_addr <= addr_nxt;
      fast_hit <= win_valid && (fast0 || fast1);
    end
  end

  // Read mux; unmapped offsets in the window read zero
  always_comb
  begin
    rd_nxt = REG_RESET;
    if (off <= OFF_PRIO6)
    begin
      rd_nxt = prio_r[off[2:0]];
    end
    else
    begin
      unique case (off)
        OFF_VBASE: rd_nxt = vbase_r;
        OFF_FM0: rd_nxt = fm0_r;
        OFF_FVL0: rd_nxt = fvl0_r;
        OFF_FVH0: rd_nxt = fvh0_r;
        OFF_FM1: rd_nxt = fm1_r;
        OFF_FVL1: rd_nxt = fvl1_r;
        OFF_FVH1: rd_nxt = fvh1_r;
        OFF_PEND0: rd_nxt = pending[15:0];
        OFF_PEND1: rd_nxt = pending[31:16];
        OFF_PEND2: rd_nxt = pending[47:32];
        OFF_PEND3: rd_nxt = pending[63:48];
        OFF_CTRL:
        begin
          rd_nxt = CTRL_ONES;
          rd_nxt[CTRL_INT_BIT] = irq_valid;
          rd_nxt[CTRL_LVL_LSB +: 2] = presented_level;
          rd_nxt[CTRL_VEC_LSB +: VEC_W] = vector_num;
          rd_nxt[CTRL_DIS_BIT] = global_irq_off_r;
        end
        default: rd_nxt = REG_RESET;
      endcase
    end
  end

  // Read data and acknowledge, one cycle after the strobe
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_rdata <= REG_RESET;
      bus_ack <= 1'b0;
    end
    else
    begin
      bus_ack <= wr_en || rd_en;
      bus_rdata <= rd_en ? rd_nxt : REG_RESET;
    end
  end

  // Checks
  sequence prio0_write_s;
    wr_en && off == OFF_PRIO0 && !rd_en;
  endsequence

  sequence prio0_read_s;
    rd_en && !wr_en && off == OFF_PRIO0;
  endsequence

  // Reserved pair reads zero after any write
  reserved_pair_zero_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    prio0_write_s ##1 prio0_read_s |=> bus_rdata[11:10] == 2'h0)
    else $error("reserved priority bits read nonzero");

  // Priority register 3 write then read returns the data
  prio_readback_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (wr_en && off == OFF_PRIO3) ##1 (rd_en && !wr_en && off == OFF_PRIO3)
    |=> bus_rdata == $past(bus_wdata, 2))
    else $error("priority register readback mismatch");

  // Access outside the window is not acknowledged
  outside_no_ack_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    (bus_rd || bus_wr) && !hit |=> !bus_ack)
    else $error("ack for address outside window");

  // Vector base top bits always zero
  vbase_top_zero_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    rd_en && off == OFF_VBASE |=> bus_rdata[15:14] == 2'h0)
    else $error("vector base top bits nonzero");

  // Fast match upper bits and high address upper bits
  fast_regs_upper_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    fm0_r[15:VEC_W] == '0 && fm1_r[15:VEC_W] == '0 &&
    fvh0_r[15:FVH_W] == '0 && fvh1_r[15:FVH_W] == '0)
    else $error("fast register reserved bits set");

  // Pending register 0 shows enabled requests
  pending_view_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    rd_en && off == OFF_PEND0 |=>
    bus_rdata == $past(irq_src[15:0] & src_on[15:0]))
    else $error("pending view mismatch");

  disabled_loses_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    win_valid |-> src_on[win_src] && irq_src[win_src])
    else $error("disabled source won arbitration");

  // Normal address joins base and vector
  normal_addr_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    win_valid && !fast0 && !fast1 |=>
    vector_addr == {$past(vbase_r[VBASE_W-1:0]), vector_num})
    else $error("normal vector address wrong");

  // Fast match supplies the programmed address
  fast_addr_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    win_valid && fast0 |=> fast_hit &&
    vector_addr == {$past(fvh0_r[FVH_W-1:0]), $past(fvl0_r)})
    else $error("fast vector address wrong");

  // Presented code follows the winning level
  present_code_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    ##1 presented_level == (($past(win_valid) && !$past(global_irq_off_r))
    ? iprm_present($past(win_lvl)) : PRES_NONE))
    else $error("presented level code wrong");

  // No lower-numbered source pending at the winning level
  lowest_wins_a: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    win_valid |-> (lvl_req[win_lvl] & ((64'h1 << win_src) - 64'h1)) == '0
    && !(|lvl_req[3] && win_lvl != 2'h3))
    else $error("winner not lowest at highest level");

endmodule : iprm_core

// ---- sim/iprm_core_model.sv ----
// Behavioural model of the processor core that takes interrupts.
// Assumes the arbiter outputs are registered on rising sys_clk.
`timescale 1ns/100ps
module iprm_core_model
  import iprm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic irq_valid,
  input wire logic [1:0] presented_level,
  input wire logic [ADDR_W-1:0] vector_addr,
  input wire logic [1:0] mask_level,
  output logic taken,
  output logic [ADDR_W-1:0] taken_addr
);
  // Core accepts only a level above its own mask, as a real core would
  // level code compare
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      taken <= 1'b0;
      taken_addr <= '0;
    end
    else if (irq_valid && (presented_level > mask_level))
    begin
      // Vector fetch address captured on acceptance
      taken <= 1'b1;
      taken_addr <= vector_addr;
    end
    else
    begin
      taken <= 1'b0;
    end
  end
endmodule : iprm_core_model

// ---- sim/test_interrupt_priority_register_map.sv ----
// Self-checking bench for the interrupt arbiter register map.
// Assumes iprm_pkg compiled first and the core model beside it.
`timescale 1ns/100ps
module test_interrupt_priority_register_map
  import iprm_pkg::*;
;
  logic sys_clk = 1'b0; // 50 MHz system clock
  logic resetn = 1'b0; // Async reset, active low
  logic [23:0] bus_addr = '0;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [15:0] bus_wdata = '0;
  logic [15:0] bus_rdata;
  logic bus_ack;
  logic [NUM_SRC-1:0] irq_src = '0; // Request lines, driven at negedge
  logic irq_valid;
  logic [1:0] presented_level;
  logic [VEC_W-1:0] vector_num;
  logic [ADDR_W-1:0] vector_addr;
  logic fast_hit;
  logic taken; // Core model accepted a request
  logic [ADDR_W-1:0] taken_addr;
  int fails = 0;
  int checks_done = 0;
  wire [31:0] obs = {fast_hit, irq_valid, presented_level, vector_num,
                     vector_addr}; // All core-facing outputs packed

  always #10 sys_clk = ~sys_clk;

  iprm_core dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .irq_src(irq_src), .irq_valid(irq_valid),
    .presented_level(presented_level), .vector_num(vector_num),
    .vector_addr(vector_addr), .fast_hit(fast_hit));

  // Mask zero: the core takes every presented level
  iprm_core_model core_u (.sys_clk(sys_clk), .resetn(resetn),
    .irq_valid(irq_valid), .presented_level(presented_level),
    .vector_addr(vector_addr), .mask_level(2'h0), .taken(taken),
    .taken_addr(taken_addr));

  // Verdict printed once, from here only
  task automatic final_report;
    if (fails == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_irq(input logic [31:0] exp);
    checks_done++;
    if (obs !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, obs, exp);
    end
  endtask : check_irq

  // Word address of a register inside the module window
  function automatic logic [23:0] ba(input logic [4:0] off);
    ba = IPRM_BASE_ADDR + {19'h0, off};
  endfunction : ba

  // Writable bits per offset; the rest must read as zero
  function automatic logic [15:0] exp_mask(input logic [4:0] off);
    case (off)
      OFF_PRIO0: exp_mask = PRIO0_MASK;
      5'h02: exp_mask = PRIO2_MASK;
      OFF_VBASE: exp_mask = VBASE_MASK;
      OFF_FM0, OFF_FM1: exp_mask = FM_MASK;
      OFF_FVH0, OFF_FVH1: exp_mask = FVH_MASK;
      default: exp_mask = PRIO_MASK;
    endcase
  endfunction : exp_mask

  // One-cycle write strobe, ack checked one cycle later
  task automatic bus_write(input logic [23:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge sys_clk);
    bus_wr = 1'b0;
    check_word({15'h0, bus_ack}, 16'h0001);
  endtask : bus_write

  // One-cycle read strobe; data and ack compared in the answer cycle
  task automatic bus_read(input logic [23:0] a, input logic [15:0] exp,
                          input logic exp_ack);
    @(negedge sys_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge sys_clk);
    bus_rd = 1'b0;
    check_word({15'h0, bus_ack}, {15'h0, exp_ack});
    check_word(bus_rdata, exp);
  endtask : bus_read

  // Change requests and let the registered outputs follow
  task automatic set_src(input logic [NUM_SRC-1:0] s);
    @(negedge sys_clk);
    irq_src = s;
    @(negedge sys_clk);
  endtask : set_src

  // Write then read of one register on consecutive edges
  task automatic write_read(input logic [23:0] a, input logic [15:0] d,
                            input logic [15:0] exp);
    @(negedge sys_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge sys_clk);
    bus_wr = 1'b0;
    bus_rd = 1'b1;
    check_word({15'h0, bus_ack}, 16'h0001);
    @(negedge sys_clk);
    bus_rd = 1'b0;
    check_word({15'h0, bus_ack}, 16'h0001);
    check_word(bus_rdata, exp);
  endtask : write_read

  initial
  begin
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    // Reset values over the whole map, then reserved and foreign places
    for (int i = 0; i < 18; i++)
      bus_read(ba(i[4:0]), REG_RESET, 1'b1);
    bus_read(ba(OFF_CTRL), CTRL_ONES, 1'b1);
    bus_read(ba(5'h12), 16'h0000, 1'b1);
    bus_read(24'h00f100, 16'h0000, 1'b0);
    bus_read(24'h00f060, 16'h0000, 1'b0);
    // Ones at offsets 0 to 14: only documented bits stick
    for (int i = 0; i < 15; i++)
      bus_write(ba(i[4:0]), 16'hffff);
    for (int i = 0; i < 14; i++)
      bus_read(ba(i[4:0]), exp_mask(i[4:0]), 1'b1);
    bus_read(ba(OFF_PEND0), 16'h0000, 1'b1);
    // Back-to-back write and read: reserved pair and plain readback
    write_read(ba(OFF_PRIO0), 16'hffff, PRIO0_MASK);
    write_read(ba(OFF_PRIO3), 16'ha5c3, 16'ha5c3);
    for (int i = 0; i < 14; i++)
      bus_write(ba(i[4:0]), 16'h0000);
    bus_write(ba(OFF_VBASE), 16'h1234);
    // Disabled source never wins
    set_src(64'h1);
    check_irq({1'b0, 1'b0, PRES_NONE, 7'h00, 14'h1234, 7'h00});
    bus_write(ba(OFF_PRIO0), 16'h4000);
    @(negedge sys_clk);
    check_irq({1'b0, 1'b1, PRES_L1, 7'h00, 14'h1234, 7'h00});
    // Higher level beats lower number
    bus_write(ba(OFF_PRIO0), 16'h7000);
    set_src(64'h3);
    check_irq({1'b0, 1'b1, PRES_L23, 7'h01, 14'h1234, 7'h01});
    // Equal level: lowest number wins; no fast match yet
    bus_write(ba(OFF_PRIO0), 16'h4280);
    set_src(64'h19);
    check_irq({1'b0, 1'b1, PRES_L23, 7'h03, 14'h1234, 7'h03});
    // Fast set 0 replaces the base-relative address
    bus_write(ba(OFF_FM0), 16'h0003);
    bus_write(ba(OFF_FVL0), 16'habcd);
    bus_write(ba(OFF_FVH0), 16'h0015);
    @(negedge sys_clk);
    check_irq({1'b1, 1'b1, PRES_L23, 7'h03, 5'h15, 16'habcd});
    check_word(taken_addr[15:0], 16'habcd);
    check_word({15'h0, taken}, 16'h0001);
    // Fast set 1 after source three is turned off
    bus_write(ba(OFF_FM1), 16'h0004);
    bus_write(ba(OFF_FVL1), 16'h1111);
    bus_write(ba(OFF_FVH1), 16'h0002);
    bus_write(ba(OFF_PRIO0), 16'h4080);
    @(negedge sys_clk);
    check_irq({1'b1, 1'b1, PRES_L23, 7'h04, 5'h02, 16'h1111});
    // Pending shows enabled requests only; source five is off
    set_src(64'h31);
    bus_read(ba(OFF_PEND0), 16'h0011, 1'b1);
    set_src(64'h8000_0000_0000_0000);
    bus_read(ba(OFF_PEND3), 16'h8000, 1'b1);
    check_word({9'h0, vector_num}, 16'h003f);
    // Global off hides the request from the core
    set_src(64'h1);
    bus_write(ba(OFF_CTRL), 16'h0020);
    @(negedge sys_clk);
    check_irq({1'b0, 1'b0, PRES_NONE, 7'h00, 14'h1234, 7'h00});
    bus_read(ba(OFF_CTRL), 16'h003c, 1'b1);
    bus_write(ba(OFF_CTRL), 16'h0000);
    @(negedge sys_clk);
    // Level one presents code 10 in bits 14:13
    bus_read(ba(OFF_CTRL), 16'hc01c, 1'b1);
    // Code 01 outside the first register means level 0
    set_src(64'h100);
    bus_write(ba(OFF_PRIO1), 16'h4000);
    @(negedge sys_clk);
    check_irq({1'b0, 1'b1, PRES_L0, 7'h08, 14'h1234, 7'h08});
    final_report;
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial
  begin
    #200000;
    fails++;
    final_report;
  end
endmodule : test_interrupt_priority_register_map
